/* verilog/ccx_pkg.sv */
/*
  Shared constants and types of the compare/call/logic execution slice.
  Assumes one CPU clock and an 8-bit register file addressed by byte.
*/
package ccx_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // opcodes
  localparam logic [7:0] OP_AND_RR   = 8'h52;
  localparam logic [7:0] OP_AND_RI   = 8'h53;
  localparam logic [7:0] OP_AND_RG   = 8'h54;
  localparam logic [7:0] OP_AND_IR   = 8'h55;
  localparam logic [7:0] OP_AND_IM   = 8'h56;
  localparam logic [7:0] OP_CP_RR    = 8'hA2;
  localparam logic [7:0] OP_CP_RI    = 8'hA3;
  localparam logic [7:0] OP_CP_RG    = 8'hA4;
  localparam logic [7:0] OP_CP_IR    = 8'hA5;
  localparam logic [7:0] OP_CP_IM    = 8'hA6;
  localparam logic [7:0] OP_CALL_DA  = 8'hF6;
  localparam logic [7:0] OP_CALL_IRR = 8'hF4;
  localparam logic [7:0] OP_CCF      = 8'hEF;
  localparam logic [7:0] OP_CLR_R    = 8'hB0;
  localparam logic [7:0] OP_CLR_IR   = 8'hB1;
  localparam logic [7:0] OP_COM_R    = 8'h60;
  localparam logic [7:0] OP_COM_IR   = 8'h61;

  ////////////////////////////////////////////////////////////////////////////
  // cycle counts, flag layout, reset values
  localparam logic [3:0]  CYC_SHORT    = 4'h4;
  localparam logic [3:0]  CYC_LONG     = 4'h6;
  localparam logic [3:0]  CYC_CALL_IRR = 4'hC;
  localparam logic [3:0]  CYC_CALL_DA  = 4'hE;
  localparam int          F_C          = 7;
  localparam int          F_Z          = 6;
  localparam int          F_S          = 5;
  localparam int          F_V          = 4;
  localparam logic [7:0]  M_C          = 8'(1) << F_C;
  localparam logic [7:0]  M_ZSV        = (8'(1) << F_Z) | (8'(1) << F_S) | (8'(1) << F_V);
  localparam logic [15:0] RST_PC       = 16'h0000;
  localparam logic [7:0]  RST_SP       = 8'h00;
  localparam logic [7:0]  RST_FLAGS    = 8'h00;
  localparam logic [3:0]  WORK_PAGE    = 4'hC;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [2:0] {OC_AND, OC_CP, OC_CALL, OC_CCF, OC_CLR, OC_COM, OC_NOP} ccx_op_t;
  typedef enum logic [2:0] {SM_WORK, SM_WIND, SM_REG, SM_IND, SM_IMM, SM_NONE} ccx_src_t;
  typedef enum logic [2:0] {
    ST_OP = 3'b000, ST_B1 = 3'b001, ST_B2 = 3'b011, ST_PTR = 3'b010,
    ST_SRC = 3'b110, ST_DST = 3'b111, ST_PUSH = 3'b101, ST_PAD = 3'b100
  } ccx_state_t;
  typedef struct packed {
    ccx_op_t    op;
    ccx_src_t   src;
    logic       ind;
    logic [1:0] len;
    logic [3:0] cyc;
  } ccx_dec_t;

endpackage : ccx_pkg

/* verilog/ccx_alu_if.sv */
/*
  Operand and flag bundle between the sequencer and the arithmetic unit.
  Assumes both ends sit on the same clock; the unit itself is combinational.
*/
interface ccx_alu_if;
  import ccx_pkg::*;
  ccx_op_t    op;
  logic [7:0] dstVal;
  logic [7:0] srcVal;
  logic [7:0] flagsIn;
  logic [7:0] result;
  logic [7:0] flagsOut;
  modport core (output op, dstVal, srcVal, flagsIn, input result, flagsOut);
  modport alu  (input op, dstVal, srcVal, flagsIn, output result, flagsOut);
endinterface : ccx_alu_if

/* verilog/ccx_alu.sv */
/*
  Result and flag logic for and, compare, complement, clear and carry toggle.
  Assumes the caller registers the outputs; purely combinational.
*/
module ccx_alu
  import ccx_pkg::*;
(
  ccx_alu_if.alu bus
);
  logic [8:0] diff;
  logic [7:0] res;
  logic [7:0] updMask;
  logic [7:0] newBits;
  logic       isCp;
  logic       ovf;
  logic       newC;

  assign diff    = {1'b0, bus.dstVal} - {1'b0, bus.srcVal};
  assign isCp    = bus.op == OC_CP;
  // operands of opposite sign and the difference carries the source sign
  assign ovf     = (bus.dstVal[7] != bus.srcVal[7]) && (diff[7] == bus.srcVal[7]); // [RL12]
  assign res     = (bus.op == OC_AND) ? (bus.dstVal & bus.srcVal) :              // [RL1]
                   (bus.op == OC_COM) ? ~bus.dstVal :                           // [RL8]
                   (bus.op == OC_CLR) ? 8'h00 : diff[7:0];                      // [RL10]
  assign newC    = isCp ? diff[8] : ~bus.flagsIn[F_C];                          // [RL11] [RL6]
  assign newBits = (8'(newC) << F_C) | (8'(res == 8'h00) << F_Z) | (8'(res[7]) << F_S)
                 | (8'(isCp && ovf) << F_V);                                    // [RL2] [RL9] [RL13]
  // decimal-adjust and half-carry are never in the mask
  assign updMask = isCp ? (M_C | M_ZSV) :
                   ((bus.op == OC_AND) || (bus.op == OC_COM)) ? M_ZSV :
                   (bus.op == OC_CCF) ? M_C : 8'h00;
  assign bus.result   = res;
  assign bus.flagsOut = (bus.flagsIn & ~updMask) | (newBits & updMask);
endmodule : ccx_alu

/* verilog/ccx_exec.sv */
/*
  Multi-cycle sequencer for and, compare, call, carry toggle, clear and complement.
  Assumes program memory and register file answer in the same cycle as the
  registered address; writes land on the edge after the write strobe.
*/
// Notes on behaviour
// (RL1) And stores dst AND src into dst; source untouched.
// (RL2) And: Z on zero, S from bit 7, V cleared, C/D/H kept.
// (RL3) And opcodes 52 (4 cycles), 53 to 56 (6 cycles).
// (RL4) Call pushes low return byte at SP-1, then high byte at SP-2.
// (RL5) Call loads PC with target; F6 3 bytes 14 cycles, F4 12; flags kept.
// (RL6) Opcode EF inverts carry only, in 4 cycles.
// (RL7) B0 and B1 clear the destination in 4 cycles, flags kept.
// (RL8) 60 and 61 invert every destination bit in 4 cycles.
// (RL9) Complement: Z on zero, S from bit 7, V cleared, C/D/H kept.
// (RL10) Compare forms dst minus src for flags only; nothing written.
// (RL11) Compare sets carry on borrow, clears it otherwise.
// (RL12) Compare V: operand signs differ and difference has source sign.
// (RL13) Compare: Z on zero, S on negative, D and H kept.
// (RL14) Compare opcodes A2, A3 two bytes; A4 to A6 three bytes.
// (RL15) Indirect call target from even/odd pair, even register is high byte.
module ccx_exec
  import ccx_pkg::*;
(
  input  logic        clock,
  input  logic        rstn,
  input  logic        ce,
  output logic [15:0] pmAddr,
  input  logic [7:0]  pmData,
  output logic [7:0]  rfAddr,
  input  logic [7:0]  rfRdata,
  output logic [7:0]  rfWdata,
  output logic        rfWe,
  output logic [7:0]  stkAddr,
  output logic [7:0]  stkWdata,
  output logic        stkWe,
  input  logic        flagsLoad,
  input  logic [7:0]  flagsIn,
  input  logic        spLoad,
  input  logic [7:0]  spIn,
  output logic [7:0]  flags,
  output logic [7:0]  sp,
  output logic [15:0] pc,
  output logic        illegalOp,
  output logic        instrDone
);
  ccx_state_t state_ff, nxt_state, nsRaw;
  ccx_dec_t   dec_ff, nxt_dec, decNow, dec;
  logic [3:0]  cnt_ff, nxt_cnt;
  logic [15:0] pc_ff, nxt_pc, pmAddr_ff, nxt_pmAddr, tgt_ff, nxt_tgt, retAddr, newPc;
  logic [7:0]  opc_ff, nxt_opc, b1_ff, nxt_b1, srcVal_ff, nxt_srcVal, dstAddr_ff, nxt_dstAddr;
  logic [7:0]  rfAddr_ff, nxt_rfAddr, rfWdata_ff, nxt_rfWdata, stkAddr_ff, nxt_stkAddr;
  logic [7:0]  stkWdata_ff, nxt_stkWdata, sp_ff, nxt_sp, flags_ff, nxt_flags;
  logic [7:0]  b1Now, dstA, srcA, spDec, rdA, wA, wD;
  logic        rfWe_ff, nxt_rfWe, stkWe_ff, nxt_stkWe, illegal_ff, nxt_illegal;
  logic        done_ff, nxt_done, rdReq, wrReq, pushLo, pushHi, goOperand, updFlags;
  logic        finish, shortForm, srcInd;

  function automatic ccx_dec_t decode(input logic [7:0] o);
    ccx_dec_t d;
    d = '{OC_NOP, SM_NONE, 1'b0, 2'h1, CYC_SHORT};
    case (o)
      OP_AND_RR:   d = '{OC_AND, SM_WORK, 1'b0, 2'h2, CYC_SHORT};
      OP_AND_RI:   d = '{OC_AND, SM_WIND, 1'b0, 2'h2, CYC_LONG};
      OP_AND_RG:   d = '{OC_AND, SM_REG, 1'b0, 2'h3, CYC_LONG};
      OP_AND_IR:   d = '{OC_AND, SM_IND, 1'b0, 2'h3, CYC_LONG};
      OP_AND_IM:   d = '{OC_AND, SM_IMM, 1'b0, 2'h3, CYC_LONG};
      OP_CP_RR:    d = '{OC_CP, SM_WORK, 1'b0, 2'h2, CYC_SHORT};
      OP_CP_RI:    d = '{OC_CP, SM_WIND, 1'b0, 2'h2, CYC_LONG};
      OP_CP_RG:    d = '{OC_CP, SM_REG, 1'b0, 2'h3, CYC_LONG};
      OP_CP_IR:    d = '{OC_CP, SM_IND, 1'b0, 2'h3, CYC_LONG};
      OP_CP_IM:    d = '{OC_CP, SM_IMM, 1'b0, 2'h3, CYC_LONG};
      OP_CALL_DA:  d = '{OC_CALL, SM_NONE, 1'b0, 2'h3, CYC_CALL_DA};
      OP_CALL_IRR: d = '{OC_CALL, SM_NONE, 1'b1, 2'h2, CYC_CALL_IRR};
      OP_CCF:      d = '{OC_CCF, SM_NONE, 1'b0, 2'h1, CYC_SHORT};
      OP_CLR_R:    d = '{OC_CLR, SM_NONE, 1'b0, 2'h2, CYC_SHORT};
      OP_CLR_IR:   d = '{OC_CLR, SM_NONE, 1'b1, 2'h2, CYC_SHORT};
      OP_COM_R:    d = '{OC_COM, SM_NONE, 1'b0, 2'h2, CYC_SHORT};
      OP_COM_IR:   d = '{OC_COM, SM_NONE, 1'b1, 2'h2, CYC_SHORT};
      default: ;
    endcase
    return d;
  endfunction : decode

  function automatic logic [7:0] wreg(input logic [3:0] n);
    return {WORK_PAGE, n};
  endfunction : wreg

  ////////////////////////////////////////////////////////////////////////////
  // decode and operand selection
  assign decNow    = decode(pmData);                                            // [RL3] [RL14]
  assign dec       = (state_ff == ST_OP) ? decNow : dec_ff;
  assign b1Now     = (state_ff == ST_B1) ? pmData : b1_ff;
  assign shortForm = (dec.src == SM_WORK) || (dec.src == SM_WIND);
  assign srcInd    = (dec.src == SM_WIND) || (dec.src == SM_IND);
  // long forms put the source byte first except the literal form
  assign dstA      = shortForm ? wreg(b1Now[7:4]) : (dec.src == SM_IMM) ? b1Now : pmData;
  assign srcA      = shortForm ? wreg(b1Now[3:0]) : b1Now;
  assign retAddr   = pc_ff + 16'(dec.len);                                      // [RL4]
  assign spDec     = sp_ff - 8'h01;
  assign finish    = (nsRaw == ST_PAD) && (cnt_ff == dec.cyc - 4'h1);
  assign newPc     = (dec.op == OC_CALL) ? tgt_ff : retAddr;                    // [RL5]

  ccx_alu_if aluBus ();
  assign aluBus.op      = dec.op;
  assign aluBus.dstVal  = rfRdata;
  assign aluBus.srcVal  = srcVal_ff;
  assign aluBus.flagsIn = flags_ff;

  ccx_alu u_alu (
    .bus (aluBus.alu)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb begin
    {rdReq, wrReq, pushLo, pushHi, goOperand, updFlags} = '0;
    rdA = 8'h00;
    wA = 8'h00;
    wD = 8'h00;
    nsRaw = state_ff;
    nxt_opc = opc_ff;
    nxt_dec = dec_ff;
    nxt_b1 = b1_ff;
    nxt_pmAddr = pmAddr_ff;
    nxt_tgt = tgt_ff;
    nxt_srcVal = srcVal_ff;
    nxt_dstAddr = dstAddr_ff;
    nxt_illegal = 1'b0;
    unique case (state_ff)
      ST_OP: begin
        nxt_opc = pmData;
        nxt_dec = decNow;
        nxt_illegal = decNow.op == OC_NOP;
        if (decNow.len == 2'h1) begin
          updFlags = decNow.op == OC_CCF;                                       // [RL6]
          nsRaw = ST_PAD;
        end else begin
          nxt_pmAddr = pc_ff + 16'h0001;
          nsRaw = ST_B1;
        end
      end
      ST_B1: begin
        nxt_b1 = pmData;
        if (dec.len == 2'h3) begin
          nxt_pmAddr = pc_ff + 16'h0002;
          nsRaw = ST_B2;
        end else begin
          goOperand = 1'b1;
        end
      end
      ST_B2: goOperand = 1'b1;
      ST_PTR: begin
        rdReq = 1'b1;
        rdA = rfRdata;
        nsRaw = ST_SRC;
        case (dec.op)
          OC_CLR: begin
            {rdReq, wrReq, wA, nsRaw} = {1'b0, 1'b1, rfRdata, ST_PAD};          // [RL7]
          end
          OC_COM: begin
            nxt_dstAddr = rfRdata;
            nsRaw = ST_DST;
          end
          OC_CALL: begin
            nxt_tgt[15:8] = rfRdata;                                            // [RL15]
            rdA = {dstAddr_ff[7:1], 1'b1};
          end
          default: ;
        endcase
      end
      ST_SRC: begin
        if (dec.op == OC_CALL) begin
          nxt_tgt[7:0] = rfRdata;
          pushLo = 1'b1;
          nsRaw = ST_PUSH;
        end else begin
          nxt_srcVal = rfRdata;
          {rdReq, rdA, nsRaw} = {1'b1, dstAddr_ff, ST_DST};
        end
      end
      ST_DST: begin
        updFlags = 1'b1;                                                        // [RL2] [RL9] [RL13]
        // compare never writes back
        wrReq = (dec.op == OC_AND) || (dec.op == OC_COM);                       // [RL10]
        wA = dstAddr_ff;
        wD = aluBus.result;                                                     // [RL1] [RL8]
        nsRaw = ST_PAD;
      end
      ST_PUSH: begin
        pushHi = 1'b1;                                                          // [RL4]
        nsRaw = ST_PAD;
      end
      ST_PAD: nsRaw = ST_PAD;
    endcase
    if (goOperand) begin
      case (dec.op)
        OC_CALL: begin
          if (dec.ind) begin
            nxt_dstAddr = {b1Now[7:1], 1'b0};
            {rdReq, rdA, nsRaw} = {1'b1, b1Now[7:1], 1'b0, ST_PTR};             // [RL15]
          end else begin
            nxt_tgt = {b1_ff, pmData};
            pushLo = 1'b1;
            nsRaw = ST_PUSH;
          end
        end
        OC_CLR: begin
          if (dec.ind) {rdReq, rdA, nsRaw} = {1'b1, b1Now, ST_PTR};
          else {wrReq, wA, nsRaw} = {1'b1, b1Now, ST_PAD};                      // [RL7]
        end
        OC_COM: begin
          nxt_dstAddr = b1Now;
          {rdReq, rdA} = {1'b1, b1Now};
          nsRaw = dec.ind ? ST_PTR : ST_DST;
        end
        default: begin
          nxt_dstAddr = dstA;
          rdReq = 1'b1;
          rdA = srcA;
          nsRaw = srcInd ? ST_PTR : ST_SRC;
          if (dec.src == SM_IMM) begin
            nxt_srcVal = pmData;
            {rdA, nsRaw} = {dstA, ST_DST};
          end
        end
      endcase
    end
  end

  // bus strobes, stack and flags follow the sequencer's requests
  always_comb begin
    nxt_rfAddr = rdReq ? rdA : wrReq ? wA : rfAddr_ff;
    nxt_rfWe = wrReq;
    nxt_rfWdata = wrReq ? wD : rfWdata_ff;
    nxt_stkWe = pushLo || pushHi;
    nxt_stkAddr = nxt_stkWe ? spDec : stkAddr_ff;
    nxt_stkWdata = pushLo ? retAddr[7:0] : pushHi ? retAddr[15:8] : stkWdata_ff;
    nxt_sp = nxt_stkWe ? spDec : spLoad ? spIn : sp_ff;
    // instruction updates win over an outside flag load in the same cycle
    nxt_flags = updFlags ? aluBus.flagsOut : flagsLoad ? flagsIn : flags_ff;
    nxt_state = finish ? ST_OP : nsRaw;
    nxt_cnt = finish ? 4'h0 : cnt_ff + 4'h1;
    nxt_pc = finish ? newPc : pc_ff;
    nxt_done = finish;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers; ce low freezes everything including strobes
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      {state_ff, cnt_ff, pc_ff, pmAddr_ff} <= {ST_OP, 4'h0, RST_PC, RST_PC};
      {opc_ff, dec_ff, b1_ff, done_ff, illegal_ff} <= '0;
    end else if (ce) begin
      {state_ff, cnt_ff, pc_ff} <= {nxt_state, nxt_cnt, nxt_pc};
      pmAddr_ff <= finish ? newPc : nxt_pmAddr;
      {opc_ff, dec_ff, b1_ff, done_ff, illegal_ff} <= {nxt_opc, nxt_dec, nxt_b1, nxt_done,
                                                       nxt_illegal};
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      {srcVal_ff, dstAddr_ff, tgt_ff} <= '0;
      {sp_ff, flags_ff} <= {RST_SP, RST_FLAGS};
      {rfAddr_ff, rfWdata_ff, rfWe_ff, stkAddr_ff, stkWdata_ff, stkWe_ff} <= '0;
    end else if (ce) begin
      {srcVal_ff, dstAddr_ff, tgt_ff} <= {nxt_srcVal, nxt_dstAddr, nxt_tgt};
      {sp_ff, flags_ff} <= {nxt_sp, nxt_flags};
      {rfAddr_ff, rfWdata_ff, rfWe_ff} <= {nxt_rfAddr, nxt_rfWdata, nxt_rfWe};
      {stkAddr_ff, stkWdata_ff, stkWe_ff} <= {nxt_stkAddr, nxt_stkWdata, nxt_stkWe};
    end
  end

  assign {pmAddr, rfAddr, rfWdata, rfWe} = {pmAddr_ff, rfAddr_ff, rfWdata_ff, rfWe_ff};
  assign {stkAddr, stkWdata, stkWe} = {stkAddr_ff, stkWdata_ff, stkWe_ff};
  assign {flags, sp} = {flags_ff, sp_ff};
  assign {pc, illegalOp, instrDone} = {pc_ff, illegal_ff, done_ff};

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_and_res;
    @(posedge clock) disable iff (!rstn)
    (ce && state_ff == ST_DST && dec_ff.op == OC_AND) |=>
      rfWe_ff && rfAddr_ff == $past(dstAddr_ff)
      && rfWdata_ff == ($past(rfRdata) & $past(srcVal_ff));
  endproperty
  a_and_res: assert property (p_and_res) else $error("and result wrong"); // [RL1]
  property p_and_flg;
    @(posedge clock) disable iff (!rstn)
    (ce && state_ff == ST_DST && dec_ff.op == OC_AND) |=> !flags_ff[F_V]
      && flags_ff[F_Z] == (rfWdata_ff == 8'h00) && flags_ff[F_S] == rfWdata_ff[7]
      && flags_ff[3:0] == $past(flags_ff[3:0]) && flags_ff[F_C] == $past(flags_ff[F_C]);
  endproperty
  a_and_flg: assert property (p_and_flg) else $error("and flags wrong"); // [RL2]
  property p_and_len;
    @(posedge clock) disable iff (!rstn)
    (ce && finish && state_ff != ST_OP && opc_ff inside {[OP_AND_RR:OP_AND_IM]}) |->
      cnt_ff == ((opc_ff == OP_AND_RR) ? 4'h3 : 4'h5);
  endproperty
  a_and_len: assert property (p_and_len) else $error("and length wrong"); // [RL3]
  property p_push;
    @(posedge clock) disable iff (!rstn)
    (ce && state_ff == ST_PUSH) |=> stkWe_ff && stkAddr_ff == $past(sp_ff) - 8'h01
      && stkWdata_ff == $past(retAddr[15:8]) && $past(stkWdata_ff) == $past(retAddr[7:0]);
  endproperty
  a_push: assert property (p_push) else $error("call push wrong"); // [RL4]
  property p_call;
    @(posedge clock) disable iff (!rstn)
    (ce && finish && state_ff != ST_OP && dec_ff.op == OC_CALL) |->
      cnt_ff == ((opc_ff == OP_CALL_DA) ? 4'hD : 4'hB) ##1
      (pc_ff == $past(tgt_ff) && pmAddr_ff == $past(tgt_ff) && flags_ff == $past(flags_ff));
  endproperty
  a_call: assert property (p_call) else $error("call target or length wrong"); // [RL5]
  property p_ccf;
    @(posedge clock) disable iff (!rstn)
    (ce && state_ff == ST_OP && pmData == OP_CCF && !flagsLoad) |=>
      flags_ff == ($past(flags_ff) ^ M_C) && state_ff == ST_PAD;
  endproperty
  a_ccf: assert property (p_ccf) else $error("carry toggle wrong"); // [RL6]
  property p_clr;
    @(posedge clock) disable iff (!rstn)
    (rfWe_ff && dec_ff.op == OC_CLR) |-> rfWdata_ff == 8'h00 && flags_ff == $past(flags_ff);
  endproperty
  a_clr: assert property (p_clr) else $error("clear wrote nonzero"); // [RL7]
  property p_com;
    @(posedge clock) disable iff (!rstn)
    (ce && state_ff == ST_DST && dec_ff.op == OC_COM) |=> rfWe_ff
      && rfWdata_ff == ~$past(rfRdata) && !flags_ff[F_V] && flags_ff[F_S] == rfWdata_ff[7];
  endproperty
  a_com: assert property (p_com) else $error("complement wrong"); // [RL8]
  property p_cp_nowr;
    @(posedge clock) disable iff (!rstn)
    (dec_ff.op == OC_CP && state_ff != ST_OP) |-> !rfWe_ff;
  endproperty
  a_cp_nowr: assert property (p_cp_nowr) else $error("compare wrote back"); // [RL10]
  property p_cp_flg;
    @(posedge clock) disable iff (!rstn)
    (ce && state_ff == ST_DST && dec_ff.op == OC_CP) |=>
      flags_ff[F_C] == ($past(srcVal_ff) > $past(rfRdata))
      && flags_ff[F_Z] == ($past(srcVal_ff) == $past(rfRdata))
      && flags_ff[F_V] == (($past(rfRdata[7]) != $past(srcVal_ff[7]))
                           && (8'($past(rfRdata) - $past(srcVal_ff)) >> 7) == $past(srcVal_ff[7]));
  endproperty
  a_cp_flg: assert property (p_cp_flg) else $error("compare flags wrong"); // [RL11]
endmodule : ccx_exec

/* tb/ccx_mem_model.sv */
/*
  Far-side memories of the execution slice: program store, register file, stack.
  Assumes combinational reads and writes that land on the clock edge while ce is high.
*/
module ccx_mem_model (
  input  wire logic        clock,
  input  wire logic        ce,
  input  wire logic [15:0] pmAddr,
  output logic      [7:0]  pmData,
  input  wire logic [7:0]  rfAddr,
  output logic      [7:0]  rfRdata,
  input  wire logic [7:0]  rfWdata,
  input  wire logic        rfWe,
  input  wire logic [7:0]  stkAddr,
  input  wire logic [7:0]  stkWdata,
  input  wire logic        stkWe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] pm  [0:65535];
  logic [7:0] rf  [0:255];
  logic [7:0] stk [0:255];

  ////////////////////////////////////////////////////////////////////////////
  assign pmData  = pm[pmAddr];
  assign rfRdata = rf[rfAddr];
  // strobes repeat while ce is low, so only enabled cycles write
  always @(posedge clock) begin
    if (ce && rfWe) rf[rfAddr] <= rfWdata;
    if (ce && stkWe) stk[stkAddr] <= stkWdata;
  end
endmodule : ccx_mem_model

/* tb/test_ccx_exec.sv */
/*
  Self-checking bench: runs one program through the sequencer and checks
  cycle counts, pc, flags and final memory. Assumes the memory model beside it.
*/
module test_ccx_exec;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock, rstn, ce, rfWe, stkWe, flagsLoad, spLoad, illegalOp, instrDone;
  logic [15:0] pmAddr, pc;
  logic [7:0]  pmData, rfAddr, rfRdata, rfWdata, stkAddr, stkWdata, flagsIn, spIn;
  logic [7:0]  flags, sp;
  int          nMismatch = 0;
  int          nTests = 0;
  int          nIll = 0;
  logic [7:0]  prog [49] = '{8'hFF, 8'h52, 8'h12, 8'h53, 8'h13, 8'h54, 8'h20, 8'h30, 8'h55,
    8'h21, 8'h31, 8'h56, 8'h32, 8'hA5, 8'hEF, 8'hEF, 8'hB0, 8'h40, 8'hB1, 8'h41, 8'h60,
    8'h43, 8'h61, 8'h44, 8'hA2, 8'h12, 8'hA3, 8'h13, 8'hA4, 8'h20, 8'h30, 8'hA5, 8'h21,
    8'h31, 8'hA6, 8'h50, 8'h03, 8'hA6, 8'h51, 8'h05, 8'hA6, 8'h52, 8'h01, 8'hA6, 8'h53,
    8'hFF, 8'hF6, 8'h15, 8'h21};
  logic [15:0] rfInit [21] = '{16'hC112, 16'hC203, 16'hC307, 16'h07FD, 16'h20F0, 16'h309C,
    16'h2122, 16'h220F, 16'h313C, 16'h32F0, 16'h405A, 16'h4142, 16'h4277, 16'h43FF,
    16'h4445, 16'h450E, 16'h5002, 16'h5105, 16'h5280, 16'h537F, 16'hC020};
  logic [15:0] rfEnd [22] = '{16'hC100, 16'hC203, 16'h07FD, 16'h20F0, 16'h3090, 16'h220F,
    16'h310C, 16'h32A0, 16'h4000, 16'h4142, 16'h4200, 16'h4300, 16'h4445, 16'h45F1,
    16'h5002, 16'h5105, 16'h5280, 16'h537F, 16'hB131, 16'hB000, 16'hAF23, 16'hAE15};
  logic [3:0]  expCyc [22] = '{4, 4, 6, 6, 6, 6, 4, 4, 4, 4, 4, 4, 4, 6, 6, 6, 6, 6, 6, 6,
    14, 12};
  logic [7:0]  expFlg [22] = '{8'hFC, 8'h8C, 8'hCC, 8'hAC, 8'h8C, 8'hAC, 8'h2C, 8'hAC,
    8'hAC, 8'hAC, 8'hCC, 8'hAC, 8'hAC, 8'h8C, 8'hAC, 8'hAC, 8'hAC, 8'h4C, 8'h1C, 8'hBC,
    8'hBC, 8'hBC};
  logic [15:0] expPc [22] = '{16'h0001, 16'h0003, 16'h0005, 16'h0008, 16'h000B, 16'h000E,
    16'h000F, 16'h0010, 16'h0012, 16'h0014, 16'h0016, 16'h0018, 16'h001A, 16'h001C,
    16'h001F, 16'h0022, 16'h0025, 16'h0028, 16'h002B, 16'h002E, 16'h1521, 16'h2000};

  ////////////////////////////////////////////////////////////////////////////
  ccx_exec dut (.clock(clock), .rstn(rstn), .ce(ce), .pmAddr(pmAddr), .pmData(pmData),
    .rfAddr(rfAddr), .rfRdata(rfRdata), .rfWdata(rfWdata), .rfWe(rfWe), .stkAddr(stkAddr),
    .stkWdata(stkWdata), .stkWe(stkWe), .flagsLoad(flagsLoad), .flagsIn(flagsIn),
    .spLoad(spLoad), .spIn(spIn), .flags(flags), .sp(sp), .pc(pc), .illegalOp(illegalOp),
    .instrDone(instrDone));
  ccx_mem_model mem (.clock(clock), .ce(ce), .pmAddr(pmAddr), .pmData(pmData),
    .rfAddr(rfAddr), .rfRdata(rfRdata), .rfWdata(rfWdata), .rfWe(rfWe), .stkAddr(stkAddr),
    .stkWdata(stkWdata), .stkWe(stkWe));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    nTests++;
    if (seen !== exp) begin
      nMismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", nTests, nMismatch);
    if (nMismatch == 0 && nTests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  // counts cycles from the opcode cycle to the next instruction's first cycle
  task automatic run_step(input int i);
    logic [7:0] n;
    n = 8'h00;
    do begin
      @(negedge clock);
      flagsLoad = 1'b0;
      spLoad = 1'b0;
      n++;
      if (illegalOp === 1'b1) nIll++;
      if (i == 20 && n == 8'h02) begin
        // ce low just before the first push: nothing may move, frozen cycles are not counted
        ce = 1'b0;
        repeat (3) @(negedge clock);
        check("frozen push", {7'h00, stkWe, sp}, 16'h00B2);
        check("frozen pc", pc, 16'h002E);
        ce = 1'b1;
      end
    end while (instrDone !== 1'b1 && n < 8'h28);
    check("cycles", {8'h00, n}, {12'h000, expCyc[i]});
    check("pc", pc, expPc[i]);
    check("flags", {8'h00, flags}, {8'h00, expFlg[i]});
    $display("step %0d done", i);
  endtask : run_step

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  initial begin
    #500000;
    nMismatch++;
    end_sim();
  end

  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    // loads wait through reset and land in the first opcode cycle
    flagsLoad = 1'b1;
    flagsIn = 8'hFC;
    spLoad = 1'b1;
    spIn = 8'hB2;
    for (int a = 0; a < 65536; a++) mem.pm[a] = 8'hFF;
    for (int a = 0; a < 49; a++) mem.pm[a] = prog[a];
    mem.pm[16'h1521] = 8'hF4;
    mem.pm[16'h1522] = 8'hC1;
    foreach (rfInit[k]) mem.rf[rfInit[k][15:8]] = rfInit[k][7:0];
    repeat (16) @(posedge clock);
    @(negedge clock);
    rstn = 1'b1;
    for (int i = 0; i < 22; i++) run_step(i);
    check("illegal pulses", 16'(nIll), 16'h0001); // undecoded opcode refused
    for (int k = 0; k < 18; k++) begin
      check("rf", 16'(mem.rf[rfEnd[k][15:8]]), 16'(rfEnd[k][7:0]));
    end
    for (int k = 18; k < 22; k++) begin
      check("stack", {8'h00, mem.stk[rfEnd[k][15:8]]}, {8'h00, rfEnd[k][7:0]});
    end
    check("sp", {8'h00, sp}, 16'h00AE);
    rstn = 1'b0;
    @(negedge clock);
    check("reset pc", pc, 16'h0000);
    check("reset flags", {flags, sp}, 16'h0000);
    $display("reset test done");
    end_sim();
  end
endmodule : test_ccx_exec
